// ==== alarm_status_consts.vh ====
// Functional notes
// - External alarm flag, bit 3, sets when the alarm pin is enabled and high
// - Over-temperature flag sets when die temperature reaches +150 C or more
// - Over-temperature flag reads zero whenever the local sensor is disabled
// - Over-temperature alarm releases only once temperature falls 8 C below trip or the local sensor is disabled
// - Temperature-high flag, bit 1, sets above the programmed upper threshold
// - Temperature-low flag, bit 0, sets below the programmed lower threshold
// - General bits 7..4 show range detect for groups D, C, B, A
// - Auto mode: idle bit 3, drops on trigger, returns on stop
// - Direct mode: idle bit drops on trigger, returns when conversions complete
// - Global alarm bit 1 is the OR of every alarm flag
// - Global alarm stays set until the general status register is read
// - Data-available flag, bit 0, held clear in automatic mode
// - Direct mode: data-available 0 while converting, 1 when results ready
// - General status resets to 0x0c with reserved bit 2 reading one
// - Second alarm status resets to 0x00, upper four bits read zero
// - Temperature limit flags need N consecutive out-of-range checks before setting
// - Reading alarm status clears flags; persisting conditions set again at the next conversion cycle
`ifndef ALARM_STATUS_CONSTS_VH
`define ALARM_STATUS_CONSTS_VH

`define AW 8
`define DW 8

`define ADDR_CONTROL 8'h01
`define ADDR_COMMAND 8'h02
`define ADDR_ALARM_SECOND 8'h71
`define ADDR_GENERAL 8'h72
`define ADDR_UPPER_LO 8'h94
`define ADDR_UPPER_HI 8'h95
`define ADDR_LOWER_LO 8'h96
`define ADDR_LOWER_HI 8'h97
`define ADDR_IRQ_STATUS 8'ha0
`define ADDR_IRQ_MASK 8'ha1

`define RST_CONTROL 8'h04
`define RST_ALARM_SECOND 8'h00
`define RST_GENERAL 8'h0c
`define RST_UPPER 12'h7ff
`define RST_LOWER 12'h800
`define RST_IRQ_MASK 6'h00

`define CTL_DIRECT 0
`define CTL_EXT_EN 1
`define CTL_TEMP_EN 2
`define CTL_CONSEC_LO 4
`define CTL_CONSEC_HI 5
`define CMD_TRIGGER 0
`define CMD_STOP 1

`define ALR_LOW 0
`define ALR_HIGH 1
`define ALR_OVERTEMP 2
`define ALR_EXT 3
`define GEN_DATA_AVAIL 0
`define GEN_GLOBAL 1
`define GEN_RESERVED 2
`define GEN_IDLE 3
`define GEN_RANGE_LO 4

`define IRQ_DONE 4
`define IRQ_GLOBAL 5

`define TEMP_LSB_MDEGC 125
`define TRIP_DEGC 150
`define HYST_DEGC 8
`define TRIP_CODE (`TRIP_DEGC * 1000 / `TEMP_LSB_MDEGC)
`define HYST_CODE (`HYST_DEGC * 1000 / `TEMP_LSB_MDEGC)
`define RELEASE_CODE (`TRIP_CODE - `HYST_CODE)

`endif

// ==== consec_filter.v ====
`timescale 1ns/1ns
`default_nettype none
// Qualifies each condition bit after N consecutive checks out of range
module consec_filter #(
  parameter WIDTH = 2
) (
  input wire clk_in, // System clock
  input wire rst_n_in, // Synchronised reset, active low
  input wire check_in, // One check per conversion cycle
  input wire [1:0] n_minus1_in, // Required run length minus one
  input wire [WIDTH-1:0] cond_in, // Raw out-of-range conditions
  output reg [WIDTH-1:0] qual_out // Conditions that met the run length
);

  reg [1:0] run [0:WIDTH-1];
  integer i;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < WIDTH; i = i + 1) begin
        run[i] <= 2'h0;
      end
      qual_out <= {WIDTH{1'b0}};
    end else if (check_in) begin
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (!cond_in[i]) begin
          run[i] <= 2'h0;
          qual_out[i] <= 1'b0;
        end else if (run[i] >= n_minus1_in) begin
          qual_out[i] <= 1'b1;
        end else begin
          run[i] <= run[i] + 2'h1;
          qual_out[i] <= 1'b0;
        end
      end
    end
  end

endmodule // consec_filter
`default_nettype wire

// ==== alarm_and_general_status.v ====
`timescale 1ns/1ns
`default_nettype none
`include "alarm_status_consts.vh"
module alarm_and_general_status (
  input wire sys_clk_in, // 100 MHz system clock
  input wire rst_n_in, // Asynchronous reset, active low
  input wire [`AW-1:0] addr_in, // Register address
  input wire [`DW-1:0] wr_data_in, // Register write data
  input wire wr_en_in, // Write strobe
  input wire rd_en_in, // Read strobe
  output reg [`DW-1:0] rd_data_out, // Read data, cycle after strobe
  input wire conv_cycle_in, // Pulse at the end of each conversion cycle
  input wire alarm_input_pin_in, // External alarm pin level
  input wire [11:0] die_temp_in, // Die temperature, twos complement
  input wire [11:0] local_temp_in, // Local sensor reading, twos complement
  input wire [3:0] range_detect_in, // Supply below threshold, groups D..A on 3..0
  input wire direct_done_in, // Pulse when direct conversions complete
  input wire [4:0] first_alarm_in, // Channel flags of the first alarm register
  output reg conv_trigger_out, // Pulse: start the converter
  output reg conv_stop_out, // Pulse: stop the converter
  output reg global_alarm_out, // Copy of the global alarm bit
  output reg irq_out // Level interrupt
);

  reg rst_meta;
  reg rst_sync;
  reg [`DW-1:0] control;
  reg [11:0] upper_thresh;
  reg [11:0] lower_thresh;
  reg [3:0] alarm_flags;
  reg overtemp_active;
  reg conv_idle;
  reg data_avail;
  reg global_alarm;
  reg [3:0] range_detect;
  reg [5:0] irq_status;
  reg [5:0] irq_mask;
  reg [3:0] next_flags;
  reg next_overtemp_active;
  reg next_global;
  reg [5:0] events;
  reg [`DW-1:0] next_rd_data;
  reg [5:0] next_irq_status;
  wire [1:0] qual;
  wire direct_mode;
  wire ext_en;
  wire temp_en;
  wire wr_ctl;
  wire wr_cmd;
  wire rd_alarm;
  wire rd_general;
  wire wr_irq_status;
  wire any_alarm;
  wire [7:0] alarm_view;
  wire [7:0] general_view;
  wire above_upper;
  wire below_lower;
  wire cmd_trigger;
  wire cmd_stop;

  // Limits cut to the sensor width; the macros are plain integers
  localparam [31:0] TRIP_WIDE = `TRIP_CODE;
  localparam [31:0] RELEASE_WIDE = `RELEASE_CODE;
  localparam [11:0] TRIP_LIMIT = TRIP_WIDE[11:0];
  localparam [11:0] RELEASE_LIMIT = RELEASE_WIDE[11:0];

  function signed_ge;
    input [11:0] a;
    input [11:0] b;
    begin
      signed_ge = ($signed(a) >= $signed(b));
    end
  endfunction

  function hit;
    input [`AW-1:0] addr;
    input [`AW-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Limits are written a byte at a time; only the low nibble of the high byte is kept
  function [11:0] put_byte;
    input [11:0] old;
    input [`DW-1:0] data;
    input high;
    begin
      if (high) begin
        put_byte = {data[3:0], old[7:0]};
      end else begin
        put_byte = {old[11:8], data};
      end
    end
  endfunction

  // Reset released through two flops; assertion stays asynchronous
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign direct_mode = control[`CTL_DIRECT];
  assign ext_en = control[`CTL_EXT_EN];
  assign temp_en = control[`CTL_TEMP_EN];
  assign wr_ctl = wr_en_in & hit(addr_in, `ADDR_CONTROL);
  assign wr_cmd = wr_en_in & hit(addr_in, `ADDR_COMMAND);
  assign rd_alarm = rd_en_in & hit(addr_in, `ADDR_ALARM_SECOND);
  assign rd_general = rd_en_in & hit(addr_in, `ADDR_GENERAL);
  assign wr_irq_status = wr_en_in & hit(addr_in, `ADDR_IRQ_STATUS);
  assign cmd_trigger = wr_cmd & wr_data_in[`CMD_TRIGGER];
  assign cmd_stop = wr_cmd & wr_data_in[`CMD_STOP];
  assign above_upper = ~signed_ge(upper_thresh, local_temp_in);
  assign below_lower = ~signed_ge(local_temp_in, lower_thresh);

  // Limit comparisons only count as alarms after the run filter
  consec_filter #(
    .WIDTH(2)
  ) u_filter (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_sync),
    .check_in(conv_cycle_in & temp_en),
    .n_minus1_in(control[`CTL_CONSEC_HI:`CTL_CONSEC_LO]),
    .cond_in({above_upper, below_lower}),
    .qual_out(qual)
  );

  // Over-temperature hysteresis and flag updates
  always @* begin
    next_overtemp_active = overtemp_active;
    next_flags = alarm_flags;
    events = 6'h00;
    if (rd_alarm) begin
      next_flags = 4'h0;
    end
    if (conv_cycle_in) begin
      if (signed_ge(die_temp_in, TRIP_LIMIT)) begin
        next_overtemp_active = 1'b1;
      end else if (signed_ge(RELEASE_LIMIT, die_temp_in)) begin
        next_overtemp_active = 1'b0;
      end
      // Setting after the clear lets a persisting condition win over a read
      if (next_overtemp_active) begin
        next_flags[`ALR_OVERTEMP] = 1'b1;
        events[`ALR_OVERTEMP] = ~alarm_flags[`ALR_OVERTEMP];
      end
      if (ext_en && alarm_input_pin_in) begin
        next_flags[`ALR_EXT] = 1'b1;
        events[`ALR_EXT] = ~alarm_flags[`ALR_EXT];
      end
    end
    if (conv_cycle_in && qual[1]) begin
      next_flags[`ALR_HIGH] = 1'b1;
      events[`ALR_HIGH] = ~alarm_flags[`ALR_HIGH];
    end
    if (conv_cycle_in && qual[0]) begin
      next_flags[`ALR_LOW] = 1'b1;
      events[`ALR_LOW] = ~alarm_flags[`ALR_LOW];
    end
    if (!temp_en) begin
      next_overtemp_active = 1'b0;
      next_flags[`ALR_OVERTEMP] = 1'b0;
      next_flags[`ALR_HIGH] = 1'b0;
      next_flags[`ALR_LOW] = 1'b0;
      events[2:0] = 3'h0;
    end
    if (direct_mode && direct_done_in) begin
      events[`IRQ_DONE] = 1'b1;
    end
  end

  assign any_alarm = (|alarm_flags) | (|first_alarm_in);

  always @* begin
    next_global = global_alarm;
    if (rd_general) begin
      next_global = 1'b0;
    end
    if (any_alarm) begin
      next_global = 1'b1;
    end
  end

  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      alarm_flags <= 4'h0;
      overtemp_active <= 1'b0;
      global_alarm <= 1'b0;
      global_alarm_out <= 1'b0;
      range_detect <= 4'h0;
    end else begin
      alarm_flags <= next_flags;
      overtemp_active <= next_overtemp_active;
      global_alarm <= next_global;
      global_alarm_out <= next_global;
      range_detect <= range_detect_in;
    end
  end

  // Software registers
  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      control <= `RST_CONTROL;
      upper_thresh <= `RST_UPPER;
      lower_thresh <= `RST_LOWER;
      irq_mask <= `RST_IRQ_MASK;
    end else if (wr_en_in) begin
      if (wr_ctl) begin
        control <= wr_data_in;
      end
      // limits are taken as written, even if crossed
      if (hit(addr_in, `ADDR_UPPER_LO)) begin
        upper_thresh <= put_byte(upper_thresh, wr_data_in, 1'b0);
      end
      if (hit(addr_in, `ADDR_UPPER_HI)) begin
        upper_thresh <= put_byte(upper_thresh, wr_data_in, 1'b1);
      end
      if (hit(addr_in, `ADDR_LOWER_LO)) begin
        lower_thresh <= put_byte(lower_thresh, wr_data_in, 1'b0);
      end
      if (hit(addr_in, `ADDR_LOWER_HI)) begin
        lower_thresh <= put_byte(lower_thresh, wr_data_in, 1'b1);
      end
      if (hit(addr_in, `ADDR_IRQ_MASK)) begin
        irq_mask <= wr_data_in[5:0];
      end
    end
  end

  // Converter commands and idle tracking
  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      conv_trigger_out <= 1'b0;
      conv_stop_out <= 1'b0;
      conv_idle <= 1'b1;
      data_avail <= 1'b0;
    end else begin
      conv_trigger_out <= cmd_trigger;
      conv_stop_out <= cmd_stop;
      if (cmd_trigger) begin
        conv_idle <= 1'b0;
        data_avail <= 1'b0;
      end else if (!direct_mode) begin
        if (cmd_stop) begin
          conv_idle <= 1'b1;
        end
        data_avail <= 1'b0;
      end else if (direct_done_in) begin
        conv_idle <= 1'b1;
        data_avail <= 1'b1;
      end else if (cmd_stop) begin
        conv_idle <= 1'b1;
      end
    end
  end

  // Interrupt status: set wins over the write-one clear
  always @* begin
    next_irq_status = irq_status;
    if (wr_irq_status) begin
      next_irq_status = next_irq_status & ~wr_data_in[5:0];
    end
    next_irq_status = next_irq_status | events;
    if (next_global && !global_alarm) begin
      next_irq_status[`IRQ_GLOBAL] = 1'b1;
    end
  end

  // Interrupt output lags the status by a cycle so it stays a flop output
  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      irq_status <= 6'h00;
      irq_out <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_out <= |(irq_status & irq_mask);
    end
  end

  assign alarm_view = {4'h0, alarm_flags};
  assign general_view = {range_detect, conv_idle, 1'b1, global_alarm, data_avail};

  always @* begin
    case (addr_in)
      `ADDR_CONTROL: next_rd_data = control;
      `ADDR_ALARM_SECOND: next_rd_data = alarm_view;
      `ADDR_GENERAL: next_rd_data = general_view;
      `ADDR_UPPER_LO: next_rd_data = upper_thresh[7:0];
      `ADDR_UPPER_HI: next_rd_data = {4'h0, upper_thresh[11:8]};
      `ADDR_LOWER_LO: next_rd_data = lower_thresh[7:0];
      `ADDR_LOWER_HI: next_rd_data = {4'h0, lower_thresh[11:8]};
      `ADDR_IRQ_STATUS: next_rd_data = {2'h0, irq_status};
      `ADDR_IRQ_MASK: next_rd_data = {2'h0, irq_mask};
      default: next_rd_data = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      rd_data_out <= 8'h00;
    end else if (rd_en_in) begin
      rd_data_out <= next_rd_data;
    end else begin
      rd_data_out <= 8'h00;
    end
  end

endmodule // alarm_and_general_status
`default_nettype wire

// ==== alarm_status_checker_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "alarm_status_consts.vh"
module alarm_status_checker (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Reset, active low
  input wire logic [7:0] addr_in, // Address
  input wire logic [7:0] wr_data_in, // Write data
  input wire logic wr_en_in, // Write strobe
  input wire logic rd_en_in, // Read strobe
  input wire logic [7:0] rd_data_out, // Read data
  input wire logic [3:0] range_detect_in, // Range detect
  input wire logic [4:0] first_alarm_in, // First register flags
  input wire logic conv_trigger_out, // Trigger pulse
  input wire logic conv_stop_out, // Stop pulse
  input wire logic global_alarm_out // Global alarm
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire rg = rd_en_in && addr_in == `ADDR_GENERAL;
  wire ra = rd_en_in && addr_in == `ADDR_ALARM_SECOND;
  wire cw = wr_en_in && addr_in == `ADDR_COMMAND;
  wire tw = cw && wr_data_in[0];
  a_read_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 8'h00) else $error("read data not idle");
  a_trigger_pulse: assert property (tw |=> conv_trigger_out) else $error("no trigger pulse");
  a_trigger_cause: assert property (conv_trigger_out |-> $past(tw)) else $error("trigger without write");
  a_stop_pulse: assert property (cw && wr_data_in[1] && !wr_data_in[0] |=> conv_stop_out) else $error("no stop");
  a_global_bit_copy: assert property (
    $past(rg) |-> rd_data_out[1] == $past(global_alarm_out)) else $error("global bit differs");
  a_reserved_one: assert property ($past(rg) |-> rd_data_out[2]) else $error("reserved bit low");
  a_range_bits: assert property (
    $past(rg) && $past(range_detect_in, 2) == $past(range_detect_in)
    |-> rd_data_out[7:4] == $past(range_detect_in)) else $error("range bits wrong");
  a_alarm_upper_zero: assert property ($past(ra) |-> rd_data_out[7:4] == 4'h0) else $error("upper bits set");
  // Only a read of the general register may drop the global alarm
  a_global_clear: assert property ($fell(global_alarm_out) |-> $past(rg)) else $error("global fell");
  a_global_first: assert property (
    first_alarm_in != 5'h00 |-> ##[1:3] global_alarm_out) else $error("first flags ignored");
  c_global_read: cover property (rg ##1 rd_data_out[1]);
  c_global_fell: cover property ($fell(global_alarm_out));
  c_stop: cover property (conv_stop_out);
endmodule // alarm_status_checker
bind alarm_and_general_status alarm_status_checker u_chk (.sys_clk_in, .rst_n_in, .addr_in, .wr_data_in,
  .wr_en_in, .rd_en_in, .rd_data_out, .range_detect_in, .first_alarm_in, .conv_trigger_out, .conv_stop_out,
  .global_alarm_out);
`default_nettype wire

// ==== alarm_and_general_status_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "alarm_status_consts.vh"
module alarm_and_general_status_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic cc = 1'b0;
  logic pin = 1'b0;
  logic dd = 1'b0;
  logic [11:0] die = 12'h000;
  logic [11:0] lt = 12'h000;
  logic [3:0] rng = 4'h0;
  logic [4:0] fa = 5'h00;
  logic [31:0] seed = 32'h7363d0be;
  wire [7:0] rdat;
  wire trg, stp, gal, irq;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  alarm_and_general_status u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat), .conv_cycle_in(cc), .alarm_input_pin_in(pin),
    .die_temp_in(die), .local_temp_in(lt), .range_detect_in(rng), .direct_done_in(dd), .first_alarm_in(fa),
    .conv_trigger_out(trg), .conv_stop_out(stp), .global_alarm_out(gal), .irq_out(irq));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  // Expected general status with the global bit left at zero
  function automatic logic [7:0] gen(input logic [3:0] r, input logic i, input logic v);
    gen = {r, i, 1'b1, 1'b0, v};
  endfunction
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdat & m, e, n);
  endtask
  task automatic cv(input int k);
    repeat (k) begin
      @(posedge clk);
      cc <= 1'b1;
      @(posedge clk);
      cc <= 1'b0;
    end
  endtask
  task automatic ev(input logic p);
    @(posedge clk);
    pin <= p;
    cv(1);
    @(posedge clk);
    pin <= 1'b0;
  endtask
  // The first read clears stale flags so the second shows only the settled state
  task automatic ot(input logic [11:0] t, input logic [7:0] e);
    @(posedge clk);
    die <= t;
    cv(1);
    rc(`ADDR_ALARM_SECOND, 8'hf0, 8'h00, "clear");
    cv(1);
    rc(`ADDR_ALARM_SECOND, 8'h04, e, "overtemp");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(`ADDR_ALARM_SECOND, 8'hff, 8'h00, "alarm reset");
    rc(`ADDR_GENERAL, 8'hff, gen(4'h0, 1'b1, 1'b0), "general reset");
    repeat (6) begin
      seed = xs(seed);
      @(posedge clk);
      rng <= seed[3:0];
      repeat (3) @(posedge clk);
      rc(`ADDR_GENERAL, 8'hf0, {seed[3:0], 4'h0}, "range");
    end
    rc(8'h50, 8'hff, 8'h00, "unmapped");
    wr(`ADDR_CONTROL, 8'h04);
    ev(1'b1);
    rc(`ADDR_ALARM_SECOND, 8'hff, 8'h00, "ext disabled");
    wr(`ADDR_CONTROL, 8'h06);
    wr(`ADDR_IRQ_MASK, 8'h08);
    ev(1'b1);
    rc(`ADDR_ALARM_SECOND, 8'hff, 8'h08, "ext flag");
    chk({7'h0, irq}, 8'h01, "irq raised");
    rc(`ADDR_ALARM_SECOND, 8'hff, 8'h00, "read clears");
    rc(`ADDR_GENERAL, 8'h02, 8'h02, "global held");
    rc(`ADDR_GENERAL, 8'h02, 8'h00, "global cleared");
    wr(`ADDR_IRQ_STATUS, 8'hff);
    wr(`ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, irq}, 8'h00, "irq cleared");
    rc(`ADDR_IRQ_STATUS, 8'h3f, 8'h00, "status cleared");
    ev(1'b1);
    rc(`ADDR_IRQ_STATUS, 8'h08, 8'h08, "irq status");
    chk({7'h0, irq}, 8'h00, "irq masked");
    @(posedge clk);
    pin <= 1'b1;
    cv(1);
    rc(`ADDR_ALARM_SECOND, 8'hff, 8'h08, "ext again");
    cv(1);
    rc(`ADDR_ALARM_SECOND, 8'hff, 8'h08, "ext persists");
    @(posedge clk);
    pin <= 1'b0;
    wr(`ADDR_CONTROL, 8'h04);
    ot(12'd1199, 8'h00);
    ot(12'd1200, 8'h04);
    ot(12'd1137, 8'h04);
    ot(12'd1136, 8'h00);
    ot(12'd1200, 8'h04);
    wr(`ADDR_CONTROL, 8'h00);
    ot(12'd1200, 8'h00);
    wr(`ADDR_CONTROL, 8'h04);
    ot(12'd0, 8'h00);
    wr(`ADDR_UPPER_LO, 8'h00);
    wr(`ADDR_UPPER_HI, 8'h01);
    wr(`ADDR_LOWER_LO, 8'h00);
    wr(`ADDR_LOWER_HI, 8'h0f);
    for (int n = 1; n <= 4; n++) begin
      wr(`ADDR_CONTROL, 8'h04 + 8'(16 * (n - 1)));
      seed = xs(seed);
      @(posedge clk);
      lt <= 12'h101 + {2'b00, seed[9:0]};
      cv(n - 1);
      @(posedge clk);
      lt <= 12'h000;
      cv(2);
      rc(`ADDR_ALARM_SECOND, 8'h03, 8'h00, "early return");
      @(posedge clk);
      lt <= 12'h101 + {2'b00, seed[19:10]};
      cv(n + 1);
      rc(`ADDR_ALARM_SECOND, 8'h02, 8'h02, "high");
      @(posedge clk);
      lt <= 12'he00;
      cv(n + 1);
      rc(`ADDR_ALARM_SECOND, 8'h01, 8'h01, "low");
      @(posedge clk);
      lt <= 12'h000;
      cv(3);
      rc(`ADDR_ALARM_SECOND, 8'hf0, 8'h00, "clear");
      cv(1);
      rc(`ADDR_ALARM_SECOND, 8'h03, 8'h00, "in range");
    end
    wr(`ADDR_CONTROL, 8'h05);
    wr(`ADDR_COMMAND, 8'h01);
    rc(`ADDR_GENERAL, 8'h09, 8'h00, "direct busy");
    @(posedge clk);
    dd <= 1'b1;
    @(posedge clk);
    dd <= 1'b0;
    rc(`ADDR_GENERAL, 8'h09, 8'h09, "direct done");
    rc(`ADDR_IRQ_STATUS, 8'h30, 8'h30, "done and global events");
    wr(`ADDR_CONTROL, 8'h04);
    rc(`ADDR_GENERAL, 8'h09, 8'h08, "auto avail");
    wr(`ADDR_COMMAND, 8'h01);
    @(posedge clk);
    dd <= 1'b1;
    @(posedge clk);
    dd <= 1'b0;
    rc(`ADDR_GENERAL, 8'h09, 8'h00, "auto busy");
    wr(`ADDR_COMMAND, 8'h02);
    rc(`ADDR_GENERAL, 8'h09, 8'h08, "auto stopped");
    seed = xs(seed);
    @(posedge clk);
    fa <= seed[4:0] | 5'h01;
    repeat (4) @(posedge clk);
    rc(`ADDR_GENERAL, 8'h02, 8'h02, "first flags");
    complete_run();
  end
endmodule // alarm_and_general_status_tb
`default_nettype wire
